// ===== phy_mgmt_defs.vh
// Purpose: constants for the management pin logic
// Assumes: 200 MHz core clock
// Notes: definitions only
`ifndef PHY_MGMT_DEFS_VH
`define PHY_MGMT_DEFS_VH
`define CLK_PERIOD_PS 5000
`define MDC_MIN_PERIOD_PS 80000
`define MDC_MIN_HALF_CYC ((`MDC_MIN_PERIOD_PS / 2) / `CLK_PERIOD_PS)
`define PREAMBLE_BITS 6'd32
`define OP_WRITE 2'b01
`define OP_READ 2'b10
`define NUM_PORTS 4
`define NUM_REGS 32
`define REG_CTRL 5'h00
`define REG_STATUS 5'h01
`define REG_IRQ_MASK 5'h19
`define REG_IRQ_STAT 5'h1A
`define CTRL_RESET_VAL 16'h1140
`define STATUS_RESET_VAL 16'h7949
`define IRQ_MASK_RESET_VAL 16'h0000
`define STICKY_MASK 16'hFFFF
`define STRAP_SETTLE 2'd2
`endif

// ===== phy_mgmt_sync.v
// Purpose: two-flop synchroniser for a pin input
// Assumes: input is asynchronous to i_clock
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  // clock and reset
  input wire i_clock,
  input wire i_srst,
  // data
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] meta;
  always @(posedge i_clock) begin
    if (i_srst) begin
      meta <= INIT;
      o_sync <= INIT;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // phy_mgmt_sync
`default_nettype wire

// ===== phy_mgmt_pin_logic.v
// Purpose: management serial port, interrupt pins and resets of a
//   four-port PHY
// Assumes: station manager drives the management clock, at most 12.5 MHz
// Notes: small per-port register file stands in for the register map
//
// Summary of operation
// - the management clock may run at any rate from stopped to 12.5 MHz.
// - every data bit moves on the rising edge of the management clock.
// - the data line is only ever pulled low or released, never driven high.
// - each interrupt pin's polarity is taken from its strap at reset.
// - an idle interrupt pin is released so pins can be wired-OR.
// - hard reset powers down and clears every register bit to default.
// - soft reset powers down but keeps all sticky register bits.
`timescale 1ns/1ps
`default_nettype none
`include "phy_mgmt_defs.vh"
module phy_mgmt_pin_logic (
  // clock and reset
  input wire i_clock,
  input wire i_srst,
  // reset pins
  input wire i_hard_reset_n,
  input wire i_soft_reset_n,
  // management serial port
  input wire i_mdc,
  input wire i_mdio,
  output reg o_mdio,
  output reg o_mdio_oe_n,
  // port interrupt events and strap pins
  input wire [3:0] i_port_event,
  input wire [3:0] i_irq_strap,
  output reg [3:0] o_mgmt_interrupt_out,
  output reg [3:0] o_mgmt_interrupt_out_oe_n,
  // power state
  output reg o_power_down
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [3:0] pins_s;
  wire [3:0] strap_s;
  phy_mgmt_sync #(.W(4), .INIT(4'hF)) u_sync_pins (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_async({i_mdc, i_mdio, i_hard_reset_n, i_soft_reset_n}),
    .o_sync(pins_s)
  );
  phy_mgmt_sync #(.W(4), .INIT(4'hF)) u_sync_strap (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_async(i_irq_strap),
    .o_sync(strap_s)
  );
  wire mdc_s = pins_s[3];
  wire mdio_s = pins_s[2];
  wire hard_n = pins_s[1];
  wire soft_n = pins_s[0];
  reg mdc_d;
  // edge detection only; no clock rate is assumed, so a stopped clock
  // simply holds the frame where it is
  wire mdc_rise = mdc_s & ~mdc_d;
  wire hard_rst = i_srst | ~hard_n;
  // ----------------------------------------------------------------
  // frame state machine
  // ----------------------------------------------------------------
  localparam ST_PRE = 3'd0;
  localparam ST_ST = 3'd1;
  localparam ST_HDR = 3'd2;
  localparam ST_TA = 3'd3;
  localparam ST_DATA = 3'd4;
  reg [2:0] state;
  reg [5:0] cnt;
  reg [13:0] hdr;
  reg [15:0] shreg;
  reg rd_op;
  reg [1:0] port_sel;
  reg [4:0] reg_sel;
  reg [15:0] regs [0:`NUM_PORTS*`NUM_REGS-1];
  reg wr_pulse;
  reg [15:0] wr_data;
  reg [3:0] irq_pol;
  reg strap_taken;
  reg [1:0] strap_wait;
  integer k;
  function [6:0] reg_index;
    input [1:0] p;
    input [4:0] r;
    reg_index = {p, r};
  endfunction
  function [15:0] reset_value;
    input [4:0] r;
    case (r)
      `REG_CTRL: reset_value = `CTRL_RESET_VAL;
      `REG_STATUS: reset_value = `STATUS_RESET_VAL;
      `REG_IRQ_MASK: reset_value = `IRQ_MASK_RESET_VAL;
      default: reset_value = 16'h0000;
    endcase
  endfunction
  wire [13:0] next_hdr = {hdr[12:0], mdio_s};
  always @(posedge i_clock) begin
    mdc_d <= mdc_s;
    wr_pulse <= 1'b0;
    if (hard_rst | ~soft_n) begin
      state <= ST_PRE;
      cnt <= 6'd0;
      o_mdio <= 1'b0;
      o_mdio_oe_n <= 1'b1;
    end else if (mdc_rise) begin
      case (state)
        ST_PRE: begin
          if (mdio_s) begin
            if (cnt != `PREAMBLE_BITS) cnt <= cnt + 6'd1;
          end else if (cnt == `PREAMBLE_BITS) begin
            state <= ST_ST;
          end else begin
            cnt <= 6'd0;
          end
        end
        ST_ST: begin
          if (mdio_s) begin
            state <= ST_HDR;
            cnt <= 6'd0;
          end else begin
            state <= ST_PRE;
            cnt <= 6'd0;
          end
        end
        ST_HDR: begin
          hdr <= next_hdr;
          if (cnt == 6'd11) begin
            rd_op <= (next_hdr[11:10] == `OP_READ);
            port_sel <= next_hdr[6:5];
            reg_sel <= next_hdr[4:0];
            state <= (next_hdr[11:10] == `OP_READ ||
                      next_hdr[11:10] == `OP_WRITE) &&
                     next_hdr[9:7] == 3'd0 ? ST_TA : ST_PRE;
            cnt <= 6'd0;
          end else begin
            cnt <= cnt + 6'd1;
          end
        end
        ST_TA: begin
          if (cnt == 6'd0 && rd_op) begin
            shreg <= regs[reg_index(port_sel, reg_sel)];
            // second turnaround bit: pull low
            o_mdio <= 1'b0;
            o_mdio_oe_n <= 1'b0;
          end
          if (cnt == 6'd1) begin
            state <= ST_DATA;
            cnt <= 6'd0;
            if (rd_op) begin
              o_mdio_oe_n <= ~shreg[15] ? 1'b0 : 1'b1;
              shreg <= {shreg[14:0], 1'b0};
            end
          end else begin
            cnt <= cnt + 6'd1;
          end
        end
        ST_DATA: begin
          if (rd_op) begin
            // a one is a released line, never a driven high
            o_mdio_oe_n <= (cnt == 6'd15) ? 1'b1 : shreg[15];
            shreg <= {shreg[14:0], 1'b0};
          end else begin
            shreg <= {shreg[14:0], mdio_s};
          end
          if (cnt == 6'd15) begin
            state <= ST_PRE;
            cnt <= 6'd0;
            if (!rd_op) begin
              wr_pulse <= 1'b1;
              wr_data <= {shreg[14:0], mdio_s};
            end
          end else begin
            cnt <= cnt + 6'd1;
          end
        end
        default: begin
          state <= ST_PRE;
          cnt <= 6'd0;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // register file and resets
  // ----------------------------------------------------------------
  // the sticky set is a single mask: soft reset leaves masked bits alone
  always @(posedge i_clock) begin
    if (hard_rst) begin
      for (k = 0; k < `NUM_PORTS*`NUM_REGS; k = k + 1) begin
        regs[k] <= reset_value(k[4:0]);
      end
    end else if (~soft_n) begin
      for (k = 0; k < `NUM_PORTS*`NUM_REGS; k = k + 1) begin
        regs[k] <= (regs[k] & `STICKY_MASK) |
                   (reset_value(k[4:0]) & ~`STICKY_MASK);
      end
    end else begin
      if (wr_pulse && reg_sel != `REG_IRQ_STAT)
        regs[reg_index(port_sel, reg_sel)] <= wr_data;
      for (k = 0; k < `NUM_PORTS; k = k + 1) begin
        // event set wins over a clear-by-read in the same cycle
        if (i_port_event[k])
          regs[reg_index(k[1:0], `REG_IRQ_STAT)] <= 16'h0001;
        else if (mdc_rise && state == ST_TA && cnt == 6'd0 && rd_op &&
                 reg_sel == `REG_IRQ_STAT && port_sel == k[1:0])
          regs[reg_index(k[1:0], `REG_IRQ_STAT)] <= 16'h0000;
      end
    end
  end
  always @(posedge i_clock) begin
    if (hard_rst) begin
      o_power_down <= 1'b1;
    end else begin
      o_power_down <= ~soft_n;
    end
  end
  // ----------------------------------------------------------------
  // interrupt pins
  // ----------------------------------------------------------------
  // strap is caught once its synchroniser has refilled after reset; that
  // synchroniser is cleared by i_srst, so an early catch reads its init value
  always @(posedge i_clock) begin
    if (hard_rst) begin
      strap_taken <= 1'b0;
      strap_wait <= 2'd0;
      irq_pol <= 4'h0;
    end else if (!strap_taken) begin
      if (strap_wait == `STRAP_SETTLE) begin
        strap_taken <= 1'b1;
        irq_pol <= ~strap_s;
      end else begin
        strap_wait <= strap_wait + 2'd1;
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < `NUM_PORTS; g = g + 1) begin : g_irq
      wire active = |(regs[g*`NUM_REGS + `REG_IRQ_STAT] &
                      regs[g*`NUM_REGS + `REG_IRQ_MASK]);
      always @(posedge i_clock) begin
        if (hard_rst) begin
          o_mgmt_interrupt_out[g] <= 1'b0;
          o_mgmt_interrupt_out_oe_n[g] <= 1'b1;
        end else begin
          // pulled-up strap: open drain, drive low; else drive high
          o_mgmt_interrupt_out[g] <= irq_pol[g];
          o_mgmt_interrupt_out_oe_n[g] <= ~(active & strap_taken);
        end
      end
    end
  endgenerate
endmodule // phy_mgmt_pin_logic
`default_nettype wire

// ===== phy_mgmt_pin_logic_end.v
`timescale 1ns/1ps

// ===== phy_mgmt_pin_logic_sva.sv
// Purpose: port checks. Assumes: pins pass two flops. Notes: bound.
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_pin_logic_sva (
  input wire logic i_clock, i_srst, i_hard_reset_n, i_soft_reset_n, i_mdc,
  input wire logic i_mdio, o_mdio, o_mdio_oe_n, o_power_down,
  input wire logic [3:0] i_port_event, i_irq_strap, o_mgmt_interrupt_out,
  input wire logic [3:0] o_mgmt_interrupt_out_oe_n
);
  logic mdc_q;
  logic [3:0] age;
  always @(posedge i_clock) begin
    mdc_q <= i_mdc;
    if (i_srst || (i_mdc && !mdc_q)) age <= 4'h0;
    else if (age != 4'hF) age <= age + 4'h1;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  sequence s_hard; !i_hard_reset_n [*5]; endsequence
  sequence s_soft; !i_soft_reset_n [*5]; endsequence
  sequence s_run; (i_hard_reset_n && i_soft_reset_n && !i_srst) [*6];
  endsequence
  property p_od; !o_mdio_oe_n |-> !o_mdio; endproperty
  a_od: assert property (p_od) else $error("line driven high");
  property p_edge; $changed(o_mdio_oe_n) |-> age <= 4'h8; endproperty
  a_edge: assert property (p_edge) else $error("bit off edge");
  property p_pol;
    &(o_mgmt_interrupt_out_oe_n | (o_mgmt_interrupt_out ^ i_irq_strap));
  endproperty
  a_pol: assert property (p_pol) else $error("irq level");
  property p_rel; s_hard |-> &o_mgmt_interrupt_out_oe_n; endproperty
  a_rel: assert property (p_rel) else $error("irq driven");
  property p_hard; s_hard |-> o_power_down && o_mdio_oe_n; endproperty
  a_hard: assert property (p_hard) else $error("not down");
  property p_soft; s_soft |-> o_power_down; endproperty
  a_soft: assert property (p_soft) else $error("not soft down");
  property p_run; s_run |-> !o_power_down; endproperty
  a_run: assert property (p_run) else $error("stuck down");
  property p_quiet; $past(o_power_down) && o_power_down |-> o_mdio_oe_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pulled when down");
endmodule // phy_mgmt_pin_logic_sva
bind phy_mgmt_pin_logic phy_mgmt_pin_logic_sva i_sva (.*);
`default_nettype wire

// ===== mgmt_station_model.sv
// Purpose: station manager. Assumes: pull-up on data. Notes: clock idles low
`timescale 1ns/1ps
`default_nettype none
module mgmt_station_model (
  input wire logic i_clock,
  output logic o_mdc, o_pull, o_rd_valid,
  output logic [15:0] o_rd_data,
  input wire logic i_line
);
  // half period in core clocks; 8 gives the 80 ns link clock
  integer half = 8;
  // clock held low this many core clocks mid-header: a stopped clock
  integer hold = 0;
  logic [63:0] w;
  logic q;
  integer k;
  initial {o_mdc, o_pull, o_rd_valid, o_rd_data} = 19'h00000;
  task frame(input logic rd, input logic [4:0] phy, input logic [4:0] rg,
    input logic [15:0] wd);
    @(posedge i_clock);
    w = {32'hFFFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, phy, rg,
      rd ? 18'h3FFFF : {2'b10, wd}};
    for (k = 63; k >= 0; k--) begin
      if (k == 20) repeat (hold) @(posedge i_clock);
      // only pull low; a one is a release so the device can answer
      o_pull <= !w[k];
      repeat (half) @(posedge i_clock);
      o_mdc <= 1'b1;
      q = i_line;
      repeat (half) @(posedge i_clock);
      o_mdc <= 1'b0;
      if (k < 16) o_rd_data[k] = q;
    end
    o_pull <= 1'b0;
    if (rd) begin
      o_rd_valid <= 1'b1;
      @(posedge i_clock);
      o_rd_valid <= 1'b0;
    end
  endtask
endmodule // mgmt_station_model
`default_nettype wire

// ===== tb.sv
// Purpose: bench. Assumes: strap fixed after reset. Notes: reads queued
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1, i_hard_reset_n = 1'b1, i_soft_reset_n = 1'b1;
  logic [3:0] i_port_event = 4'h0, i_irq_strap = 4'h0;
  logic [15:0] d, d_exp;
  logic [15:0] expq[$];
  integer seed = 32'h9fc598c0, err_count = 0, compares = 0, cycles = 0, k;
  wire i_mdc, sm_pull, rd_valid, o_mdio, o_mdio_oe_n, o_power_down;
  wire [15:0] rd_data;
  wire [3:0] o_mgmt_interrupt_out, o_mgmt_interrupt_out_oe_n;
  wire i_mdio = !(sm_pull || (!o_mdio_oe_n && !o_mdio));
  phy_mgmt_pin_logic i_dut (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_hard_reset_n(i_hard_reset_n),
    .i_soft_reset_n(i_soft_reset_n),
    .i_mdc(i_mdc),
    .i_mdio(i_mdio),
    .o_mdio(o_mdio),
    .o_mdio_oe_n(o_mdio_oe_n),
    .i_port_event(i_port_event),
    .i_irq_strap(i_irq_strap),
    .o_mgmt_interrupt_out(o_mgmt_interrupt_out),
    .o_mgmt_interrupt_out_oe_n(o_mgmt_interrupt_out_oe_n),
    .o_power_down(o_power_down)
  );
  mgmt_station_model i_sm (.i_clock(i_clock), .o_mdc(i_mdc),
    .o_pull(sm_pull), .i_line(i_mdio), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid));
  always #2.5 i_clock = ~i_clock;
  // checked on the clock, so the read that ends the run is still compared
  always @(posedge i_clock) begin
    if (rd_valid) begin
      d_exp = expq.pop_front();
      `CHK(rd_data, d_exp)
    end
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      tally_and_finish;
    end
  end
  task pins(input logic h, input logic s);
    @(posedge i_clock);
    i_hard_reset_n <= h;
    i_soft_reset_n <= s;
    repeat (8) @(negedge i_clock);
  endtask
  task frm(input logic rd, input logic [1:0] p, input logic [4:0] r,
    input logic [15:0] v);
    if (rd) expq.push_back(v);
    i_sm.frame(rd, {3'b000, p}, r, v);
  endtask
  task tally_and_finish;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    @(posedge i_clock);
    i_irq_strap <= 4'($random(seed));
    repeat (4) @(posedge i_clock);
    i_srst <= 1'b0;
    pins(1'b1, 1'b1);
    frm(1'b1, 2'd0, 5'h00, 16'h1140);
    d = 16'($random(seed));
    frm(1'b0, 2'd1, 5'h19, d);
    i_sm.half = 40;
    i_sm.hold = 200;
    frm(1'b1, 2'd1, 5'h19, d);
    i_sm.half = 8;
    i_sm.hold = 0;
    pins(1'b1, 1'b0);
    `CHK(o_power_down, 1'b1)
    pins(1'b1, 1'b1);
    frm(1'b1, 2'd1, 5'h19, d);
    for (k = 0; k < 4; k++) begin
      frm(1'b0, k[1:0], 5'h19, 16'hFFFF);
      @(posedge i_clock);
      i_port_event <= 4'h1 << k;
      @(posedge i_clock);
      i_port_event <= 4'h0;
      repeat (8) @(negedge i_clock);
      `CHK(o_mgmt_interrupt_out_oe_n, ~(4'h1 << k))
      `CHK(o_mgmt_interrupt_out[k], ~i_irq_strap[k])
      pins(1'b0, 1'b1);
      `CHK({o_power_down, o_mgmt_interrupt_out_oe_n}, 5'h1F)
      pins(1'b1, 1'b1);
    end
    frm(1'b1, 2'd3, 5'h01, 16'h7949);
    frm(1'b1, 2'd1, 5'h19, 16'h0000);
    repeat (2) @(posedge i_clock);
    `CHK(expq.size(), 0)
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
